// ===== hw/tbs_pkg.sv
// package: status word layout, timing constants and carrier types for the terminal bus status block
package tbs_pkg;

    // register map
    localparam logic [3:0]  STATUS_WORD_OFFSET = 4'h0;
    localparam logic [15:0] STATUS_WORD_RESET  = 16'h0000;

    // status word bit positions
    localparam int BIT_BUS_ERR      = 0;
    localparam int BIT_CFG_CHANGED  = 1;
    localparam int BIT_LEN_MISMATCH = 2;
    localparam int BIT_NO_VALID_IN  = 8;
    localparam int BIT_IN_BUSY      = 9;
    localparam int BIT_OUT_BUSY     = 10;
    localparam int BIT_WATCHDOG     = 11;
    localparam int BIT_ACYCLIC      = 15;

    // timing
    localparam int CLK_FREQ_HZ       = 100_000_000;
    localparam int CYCLE_MAX_MS      = 5;
    localparam int CYCLE_MAX_CYCLES  = CLK_FREQ_HZ / 1000 * CYCLE_MAX_MS;
    localparam int BLINK_HALF_MS     = 50;
    localparam int BLINK_HALF_CYCLES = CLK_FREQ_HZ / 1000 * BLINK_HALF_MS;
    localparam int CNT_W             = 24;

    // events and levels reported by the terminal bus engine
    typedef struct packed {
        logic bus_err;
        logic cfg_changed;
        logic len_mismatch;
        logic inputs_valid;
        logic in_cycle_start;
        logic in_cycle_done;
        logic out_cycle_start;
        logic out_cycle_done;
        logic acyclic_active;
    } tbs_bus_ev_t;

    // expansion-bus link indicator states
    typedef enum logic [1:0] {
        LINK_OFF  = 2'b00,
        LINK_IDLE = 2'b01,
        LINK_ACT  = 2'b10
    } tbs_link_t;

endpackage

// ===== hw/tbs_blink.sv
// module: link/activity indicator driver for expansion-bus mode
`timescale 1ns/1ps
module tbs_blink
    import tbs_pkg::*;
#(
    parameter int HALF_CYCLES = BLINK_HALF_CYCLES
)
(
    // clock and reset
    input  wire logic core_clk,
    input  wire logic rst,
    // link state, already synchronised
    input  wire logic link_up,
    input  wire logic traffic,
    // indicator
    output logic      led_on
);

    //--------------------------------------------------------------
    // state and blink timebase
    //--------------------------------------------------------------
    tbs_link_t        state_q, state_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic             phase_q, phase_d;
    logic             led_q, led_d;

    always_comb
    begin
        state_d = state_q;
        cnt_d   = cnt_q;
        phase_d = phase_q;
        unique case (state_q)
            LINK_OFF:  state_d = link_up ? (traffic ? LINK_ACT : LINK_IDLE) : LINK_OFF;
            LINK_IDLE: state_d = !link_up ? LINK_OFF : (traffic ? LINK_ACT : LINK_IDLE);
            LINK_ACT:  state_d = !link_up ? LINK_OFF : (traffic ? LINK_ACT : LINK_IDLE);
            default:   state_d = LINK_OFF;
        endcase
        if (state_q == LINK_ACT)
        begin
            if (cnt_q == CNT_W'(HALF_CYCLES - 1))
            begin
                cnt_d   = '0;
                phase_d = !phase_q;
            end
            else
            begin
                cnt_d = cnt_q + 1'b1;
            end
        end
        else
        begin
            cnt_d   = '0;
            phase_d = 1'b0;
        end
        // off, steady, or flashing
        unique case (state_q)
            LINK_IDLE: led_d = 1'b1;
            LINK_ACT:  led_d = !phase_q;
            default:   led_d = 1'b0;
        endcase
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            state_q <= LINK_OFF;
            cnt_q   <= '0;
            phase_q <= 1'b0;
            led_q   <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            phase_q <= phase_d;
            led_q   <= led_d;
        end
    end

    assign led_on = led_q;

endmodule

// ===== hw/tbs_status.sv
// module: terminal bus coupler diagnostic status word and expansion-bus link indicator
`timescale 1ns/1ps
module tbs_status
    import tbs_pkg::*;
#(
    parameter int CYCLE_LIMIT = CYCLE_MAX_CYCLES,
    parameter int BLINK_HALF  = BLINK_HALF_CYCLES
)
(
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst,
    // terminal bus engine, same clock
    input  tbs_bus_ev_t      bus_ev,
    // software side
    input  wire logic        dev_reset_req,
    input  wire logic        task_tick,
    input  wire logic [3:0]  rd_addr,
    output logic      [15:0] rd_data,
    // expansion-bus link pins, asynchronous
    input  wire logic        link_up_pin,
    input  wire logic        traffic_pin,
    output logic             link_led
);

    //--------------------------------------------------------------
    // pin synchronisers
    //--------------------------------------------------------------
    logic [1:0] link_s1_q, link_s2_q;

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            link_s1_q <= 2'b00;
            link_s2_q <= 2'b00;
        end
        else
        begin
            link_s1_q <= {traffic_pin, link_up_pin};
            link_s2_q <= link_s1_q;
        end
    end

    //--------------------------------------------------------------
    // sticky fault flags
    //--------------------------------------------------------------
    logic             err_q, err_d;
    logic             cfg_q, cfg_d;
    logic             len_q, len_d;
    logic             valid_seen_q, valid_seen_d;

    always_comb
    begin
        // set wins over the reset request in the same cycle
        err_d        = bus_ev.bus_err | (err_q & ~dev_reset_req);
        cfg_d        = bus_ev.cfg_changed | (cfg_q & ~dev_reset_req);
        len_d        = bus_ev.len_mismatch | (len_q & ~dev_reset_req);
        // a device reset makes the inputs stale again unless fresh data comes with it
        valid_seen_d = valid_seen_q | bus_ev.inputs_valid;
        if (dev_reset_req && !bus_ev.inputs_valid)
        begin
            valid_seen_d = 1'b0;
        end
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            err_q        <= 1'b0;
            cfg_q        <= 1'b0;
            len_q        <= 1'b0;
            valid_seen_q <= 1'b0;
        end
        else
        begin
            err_q        <= err_d;
            cfg_q        <= cfg_d;
            len_q        <= len_d;
            valid_seen_q <= valid_seen_d;
        end
    end

    //--------------------------------------------------------------
    // update cycle tracking
    //--------------------------------------------------------------
    logic             in_busy_q, in_busy_d;
    logic             out_busy_q, out_busy_d;
    logic             acyc_q, acyc_d;

    always_comb
    begin
        // a start in the same cycle as a done keeps the cycle running
        in_busy_d  = bus_ev.in_cycle_start | (in_busy_q & ~bus_ev.in_cycle_done);
        out_busy_d = bus_ev.out_cycle_start | (out_busy_q & ~bus_ev.out_cycle_done);
        // registered so that this level shows with the same delay as the event bits
        acyc_d     = bus_ev.acyclic_active;
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            in_busy_q  <= 1'b0;
            out_busy_q <= 1'b0;
            acyc_q     <= 1'b0;
        end
        else
        begin
            in_busy_q  <= in_busy_d;
            out_busy_q <= out_busy_d;
            acyc_q     <= acyc_d;
        end
    end

    //--------------------------------------------------------------
    // communication watchdog
    //--------------------------------------------------------------
    logic             wdog_q, wdog_d;
    logic [CNT_W-1:0] wd_cnt_q, wd_cnt_d;

    always_comb
    begin
        // the task must tick before the bus cycle limit runs out
        wd_cnt_d = wd_cnt_q;
        // an expiry in the same cycle as a reset request wins
        wdog_d   = wdog_q & ~dev_reset_req;
        if (task_tick)
        begin
            wd_cnt_d = '0;
        end
        else if (wd_cnt_q == CNT_W'(CYCLE_LIMIT - 1))
        begin
            // counter parks at the limit, so a reset request alone cannot hide a stalled task
            wdog_d = 1'b1;
        end
        else
        begin
            wd_cnt_d = wd_cnt_q + 1'b1;
        end
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            wdog_q   <= 1'b0;
            wd_cnt_q <= '0;
        end
        else
        begin
            wdog_q   <= wdog_d;
            wd_cnt_q <= wd_cnt_d;
        end
    end

    //--------------------------------------------------------------
    // status word and read port
    //--------------------------------------------------------------
    logic [15:0]      word_d, rd_q, rd_d;

    always_comb
    begin
        // unassigned positions stay zero
        word_d = 16'h0000;
        word_d[BIT_BUS_ERR]      = err_q;
        word_d[BIT_CFG_CHANGED]  = cfg_q;
        word_d[BIT_LEN_MISMATCH] = len_q;
        word_d[BIT_NO_VALID_IN]  = ~valid_seen_q;
        word_d[BIT_IN_BUSY]      = in_busy_q;
        word_d[BIT_OUT_BUSY]     = out_busy_q;
        word_d[BIT_WATCHDOG]     = wdog_q;
        word_d[BIT_ACYCLIC]      = acyc_q;
        // only the status word is mapped; any other address reads zero
        rd_d = (rd_addr == STATUS_WORD_OFFSET) ? word_d : 16'h0000;
    end

    // the answer is registered: one cycle of latency buys a clean flop output
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            rd_q <= STATUS_WORD_RESET;
        end
        else
        begin
            rd_q <= rd_d;
        end
    end

    assign rd_data = rd_q;

    //--------------------------------------------------------------
    // link indicator
    //--------------------------------------------------------------
    tbs_blink #(
        .HALF_CYCLES (BLINK_HALF)
    ) u_blink (
        .core_clk (core_clk),
        .rst      (rst),
        .link_up  (link_s2_q[0]),
        .traffic  (link_s2_q[1]),
        .led_on   (link_led)
    );

endmodule

// ===== tb/tbs_status_sva.sv
// checker: timing of the status word and link indicator
`timescale 1ns/1ps
module tbs_status_sva
    import tbs_pkg::*;
#(
    parameter int CYCLE_LIMIT = 20,
    parameter int BLINK_HALF  = 4
)
(
    // clock and reset
    input wire logic        core_clk,
    input wire logic        rst,
    // watched ports
    input tbs_bus_ev_t      bus_ev,
    input wire logic        dev_reset_req,
    input wire logic        task_tick,
    input wire logic [3:0]  rd_addr,
    input wire logic [15:0] rd_data,
    input wire logic        link_up_pin,
    input wire logic        traffic_pin,
    input wire logic        link_led
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);
    // events show two edges after their pulse, read address taken in between
    err_set_a: assert property (bus_ev.bus_err ##1 rd_addr == 4'h0 |=> rd_data[0])
        else $error("bus error flag not set");
    err_hold_a: assert property (!dev_reset_req ##1 rd_data[0] && rd_addr == 4'h0 |=> rd_data[0])
        else $error("bus error flag lost");
    err_clr_a: assert property (dev_reset_req && !bus_ev.bus_err ##1 rd_addr == 4'h0 |=> !rd_data[0])
        else $error("bus error flag not cleared");
    cfg_set_a: assert property (bus_ev.cfg_changed ##1 rd_addr == 4'h0 |=> rd_data[1])
        else $error("config flag not set");
    len_set_a: assert property (bus_ev.len_mismatch ##1 rd_addr == 4'h0 |=> rd_data[2])
        else $error("length flag not set");
    valid_clr_a: assert property (bus_ev.inputs_valid && !dev_reset_req ##1 rd_addr == 4'h0 |=> !rd_data[8])
        else $error("no-input flag stays");
    in_busy_a: assert property (bus_ev.in_cycle_start ##1 rd_addr == 4'h0 |=> rd_data[9])
        else $error("input busy missing");
    out_done_a: assert property (bus_ev.out_cycle_done && !bus_ev.out_cycle_start ##1 rd_addr == 4'h0
        |=> !rd_data[10])
        else $error("output busy stays");
    acyc_on_a: assert property (bus_ev.acyclic_active ##1 rd_addr == 4'h0 |=> rd_data[15])
        else $error("acyclic flag missing");
    resv_zero_a: assert property (rd_data[7:3] == 5'h00 && rd_data[14:12] == 3'h0)
        else $error("reserved bits set");
    led_off_a: assert property (!link_up_pin [*6] |-> !link_led)
        else $error("indicator lit without link");
    led_on_a: assert property ((link_up_pin && !traffic_pin) [*6] |-> link_led)
        else $error("indicator dark on idle link");
    cover property (bus_ev.bus_err);
    cover property (rd_data[11]);
    cover property (traffic_pin && $fell(link_led));
endmodule
bind tbs_status tbs_status_sva #(.CYCLE_LIMIT(CYCLE_LIMIT), .BLINK_HALF(BLINK_HALF)) u_sva (
    .core_clk(core_clk), .rst(rst), .bus_ev(bus_ev), .dev_reset_req(dev_reset_req),
    .task_tick(task_tick), .rd_addr(rd_addr), .rd_data(rd_data), .link_up_pin(link_up_pin),
    .traffic_pin(traffic_pin), .link_led(link_led));

// ===== tb/tbs_chain_model.sv
// partner: chain of i/o terminals answering update cycles
`timescale 1ns/1ps
module tbs_chain_model
    import tbs_pkg::*;
#(
    parameter int LAT = 12
)
(
    // clock and reset
    input  wire logic       core_clk,
    input  wire logic       rst,
    // commands from the bench
    input  wire logic       go,
    input  wire logic [2:0] fault,
    input  wire logic       acyc,
    // events towards the coupler
    output tbs_bus_ev_t     ev
);
    int cnt_q;
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            ev <= '0;
            cnt_q <= 0;
        end
        else
        begin
            ev <= '0;
            ev.bus_err <= fault[0];
            ev.cfg_changed <= fault[1];
            ev.len_mismatch <= fault[2];
            ev.acyclic_active <= acyc;
            ev.in_cycle_start <= go;
            ev.out_cycle_start <= go;
            cnt_q <= go ? LAT : (cnt_q > 0 ? cnt_q - 1 : 0);
            // slow answer: both updates finish LAT cycles after the start
            if (cnt_q == 1)
            begin
                ev.in_cycle_done <= 1'b1;
                ev.out_cycle_done <= 1'b1;
                ev.inputs_valid <= 1'b1;
            end
        end
    end
endmodule

// ===== tb/terminal_bus_status_word_test.sv
// testbench: status word and link indicator scenarios
`timescale 1ns/1ps
module terminal_bus_status_word_test import tbs_pkg::*;;
    logic        core_clk = 1'b0;
    logic        rst = 1'b1;
    logic        go = 1'b0;
    logic [2:0]  fault = 3'h0;
    logic        acyc = 1'b0;
    logic        dev_reset_req = 1'b0;
    logic        task_tick = 1'b0;
    logic        tick_en = 1'b1;
    logic [3:0]  rd_addr = 4'h0;
    logic [15:0] rd_data;
    logic        link_up_pin = 1'b0;
    logic        traffic_pin = 1'b0;
    logic        link_led;
    logic        prev;
    tbs_bus_ev_t bus_ev;
    int          num_errors = 0;
    int          num_checks = 0;
    int          tcnt = 0;
    int          n;
    always #5 core_clk = ~core_clk;
    // task period 16 cycles stays inside the watchdog limit of 20
    always @(posedge core_clk)
    begin
        tcnt <= tcnt + 1;
        task_tick <= tick_en && (tcnt % 16 == 0);
    end
    tbs_chain_model u_chain (.core_clk(core_clk), .rst(rst), .go(go), .fault(fault), .acyc(acyc), .ev(bus_ev));
    tbs_status #(.CYCLE_LIMIT(20), .BLINK_HALF(4)) u_dut (.core_clk(core_clk), .rst(rst), .bus_ev(bus_ev),
        .dev_reset_req(dev_reset_req), .task_tick(task_tick), .rd_addr(rd_addr), .rd_data(rd_data),
        .link_up_pin(link_up_pin), .traffic_pin(traffic_pin), .link_led(link_led));
    task check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        num_checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task rd(input logic [3:0] a, input logic [15:0] e);
        @(posedge core_clk) rd_addr <= a;
        repeat (3) @(posedge core_clk);
        #1 check(rd_data, e, "status word");
    endtask
    task pulse(input logic [4:0] v);
        @(posedge core_clk) {go, fault, dev_reset_req} <= v;
        @(posedge core_clk) {go, fault, dev_reset_req} <= 5'h00;
    endtask
    task final_report();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial
    begin
        #50000;
        num_errors = num_errors + 1;
        final_report();
    end
    initial
    begin
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        rd(4'h0, 16'h0100);
        rd(4'h5, 16'h0000);
        pulse(5'h10);
        rd(4'h0, 16'h0700);
        repeat (20) @(posedge core_clk);
        rd(4'h0, 16'h0000);
        for (int i = 0; i < 3; i++)
        begin
            pulse(5'(2 << i));
            rd(4'h0, 16'((2 << i) - 1));
        end
        pulse(5'h01);
        rd(4'h0, 16'h0100);
        @(posedge core_clk) acyc <= 1'b1;
        rd(4'h0, 16'h8100);
        @(posedge core_clk) acyc <= 1'b0;
        @(posedge core_clk) tick_en <= 1'b0;
        repeat (30) @(posedge core_clk);
        rd(4'h0, 16'h0900);
        @(posedge core_clk) tick_en <= 1'b1;
        repeat (20) @(posedge core_clk);
        pulse(5'h01);
        rd(4'h0, 16'h0100);
        @(posedge core_clk) link_up_pin <= 1'b1;
        repeat (8) @(posedge core_clk);
        #1 check({15'h0000, link_led}, 16'h0001, "indicator idle");
        @(posedge core_clk) traffic_pin <= 1'b1;
        repeat (10) @(posedge core_clk);
        #1 n = 0;
        for (int i = 0; i < 32; i++)
        begin
            prev = link_led;
            @(posedge core_clk);
            #1 n += (link_led !== prev);
        end
        check(16'(n), 16'h0008, "indicator edges");
        @(posedge core_clk) link_up_pin <= 1'b0;
        repeat (8) @(posedge core_clk);
        #1 check({15'h0000, link_led}, 16'h0000, "indicator off");
        final_report();
    end
endmodule
